// >>> rtl/set_features_service_cmd_defs.vh
`ifndef SET_FEATURES_SERVICE_CMD_DEFS_VH
`define SET_FEATURES_SERVICE_CMD_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_SUBCOMMAND_SELECT 8'h00
`define OFF_PARAMETER_COUNT   8'h04
`define OFF_PARAMETER_NUMBER  8'h08
`define OFF_PARAMETER_LOW     8'h0C
`define OFF_PARAMETER_HIGH    8'h10
`define OFF_UNIT_SELECT       8'h14
`define OFF_COMMAND_CODE      8'h18
`define OFF_FAULT_DETAIL      8'h1C
`define OFF_UNIT_CONDITION    8'h20
`define OFF_FEATURE_STATE     8'h24
`define OFF_TRANSFER_STATE    8'h28
`define OFF_DATA_PORT         8'h2C

// ****************************************
// Status and error bit positions
// ****************************************
`define ST_BUSY     7
`define ST_READY    6
`define ST_FAULT    5
`define ST_SEEKDONE 4
`define ST_SERVICE  4
`define ST_XFERREQ  3
`define ST_ERRSUM   0
`define ER_ABORT    2

// ****************************************
// Reset values
// ****************************************
`define RST_STATUS  8'h40
`define RST_BYTE    8'h00
`define RST_DATA    16'h0000

// ****************************************
// Command codes
// ****************************************
`define CMD_SEEK    8'h70
`define CMD_SERVICE 8'hA2
`define CMD_SETFEAT 8'hEF

// ****************************************
// Subcommand codes
// ****************************************
`define SC_DATA8_ON   8'h01
`define SC_WCACHE_ON  8'h02
`define SC_XFER_MODE  8'h03
`define SC_APM_ON     8'h05
`define SC_STBY_ON    8'h06
`define SC_SPINUP     8'h07
`define SC_CARDPWR_ON 8'h0A
`define SC_MEDIA_OFF  8'h31
`define SC_LOOK_OFF   8'h55
`define SC_RELINT_ON  8'h5D
`define SC_SVCINT_ON  8'h5E
`define SC_REVERT_OFF 8'h66
`define SC_DATA8_OFF  8'h81
`define SC_WCACHE_OFF 8'h82
`define SC_APM_OFF    8'h85
`define SC_STBY_OFF   8'h86
`define SC_CARDPWR_OFF 8'h8A
`define SC_MEDIA_ON   8'h95
`define SC_LOOK_ON    8'hAA
`define SC_REVERT_ON  8'hCC
`define SC_RELINT_OFF 8'hDD
`define SC_SVCINT_OFF 8'hDE

// ****************************************
// Feature enable vector bit positions
// ****************************************
`define F_WCACHE  0
`define F_APM     1
`define F_STBY    2
`define F_LOOK    3
`define F_REVERT  4
`define F_RELINT  5
`define F_SVCINT  6
`define F_MEDIA   7
`define F_CARDPWR 8
`define F_DATA8   9

// ****************************************
// Transfer type field, count bits 7:3
// ****************************************
`define XT_PIO_DEF 5'h00
`define XT_PIO_FC  5'h01
`define XT_MDMA    5'h04
`define XT_UDMA    5'h08

// ****************************************
// Power management level limits
// ****************************************
`define APM_BAD_LO 8'h00
`define APM_BAD_HI 8'hFF

`endif

// >>> rtl/set_features_service_cmd.v
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "set_features_service_cmd_defs.vh"

module set_features_service_cmd #(
    parameter [9:0] FEAT_DEFAULT = 10'h000,
    parameter [7:0] PIO_DEFAULT  = 8'h00,
    parameter [7:0] DMA_DEFAULT  = 8'h00,
    parameter [7:0] APM_DEFAULT  = 8'hFE,
    parameter       HAS_WCACHE   = 1,
    parameter       CARD_CLASS   = 0,
    parameter       REMOVABLE    = 1,
    parameter       CAN_LOCK     = 1,
    parameter       CAN_EJECT    = 1,
    parameter       IORDY_OFF_OK = 1,
    parameter [2:0] MAX_PIO      = 3'h4,
    parameter [2:0] MAX_MDMA     = 3'h2,
    parameter [2:0] MAX_UDMA     = 3'h5
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Back end: bus-released command
    input  wire        rel_valid,
    input  wire [7:0]  rel_status,
    input  wire [7:0]  rel_error,
    input  wire [7:0]  rel_count,
    input  wire        device_fault,
    // Feature outputs
    output reg  [9:0]  feature_en,
    output reg  [7:0]  pio_mode,
    output reg  [7:0]  dma_mode,
    output reg  [7:0]  apm_level,
    output reg         spinup,
    output reg         cache_flush,
    output reg  [15:0] data_out
);

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_EXEC = 3'b010;
    localparam [2:0] S_SEEK = 3'b100;

    function mode_ok;
        input [2:0] limit;
        input [2:0] mode;
        begin
            mode_ok = (mode <= limit);
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg [2:0]  state_q;
    reg [7:0]  sel_q, cnt_q, num_q, lo_q, hi_q, unit_q;
    reg [7:0]  err_q, stat_q;
    reg [7:0]  lcmd_q, lsub_q, lcnt_q;
    reg        svc_pend_q;
    reg [7:0]  rstat_q, rerr_q, rcnt_q;
    reg        wr_q;
    reg [7:0]  waddr_q;

    wire       addr_ph = hsel & hready & htrans[1];
    wire [7:0] stat_rd = stat_q | ({7'h00, svc_pend_q} << `ST_SERVICE);

    // ****************************************
    // Execution decode
    // ****************************************
    reg        x_abort;
    reg [9:0]  x_feat;
    reg [7:0]  x_pio, x_dma, x_apm;
    reg        x_spin, x_flush, x_media;

    always @* begin
        x_abort = 1'b0;
        x_feat  = feature_en;
        x_pio   = pio_mode;
        x_dma   = dma_mode;
        x_apm   = apm_level;
        x_spin  = 1'b0;
        x_flush = 1'b0;
        x_media = 1'b0;
        case (lcmd_q)
            `CMD_SETFEAT: begin
                case (lsub_q)
                    `SC_XFER_MODE: begin
                        case (lcnt_q[7:3])
                            `XT_PIO_DEF: begin
                                if (lcnt_q[2:1] != 2'b00 || (lcnt_q[0] && IORDY_OFF_OK == 0))
                                    x_abort = 1'b1;
                                else
                                    x_pio = lcnt_q;
                            end
                            `XT_PIO_FC: begin
                                if (mode_ok(MAX_PIO, lcnt_q[2:0]))
                                    x_pio = lcnt_q;
                                else
                                    x_abort = 1'b1;
                            end
                            `XT_MDMA, `XT_UDMA: begin
                                // One DMA field: a new DMA mode replaces the other kind
                                if (mode_ok(lcnt_q[6] ? MAX_UDMA : MAX_MDMA, lcnt_q[2:0]))
                                    x_dma = lcnt_q;
                                else
                                    x_abort = 1'b1;
                            end
                            default: x_abort = 1'b1;
                        endcase
                    end
                    `SC_WCACHE_ON, `SC_WCACHE_OFF: begin
                        if (HAS_WCACHE == 0) begin
                            x_abort = 1'b1;
                        end else begin
                            x_feat[`F_WCACHE] = ~lsub_q[7];
                            x_flush           = lsub_q[7];
                        end
                    end
                    `SC_APM_ON: begin
                        if (lcnt_q == `APM_BAD_LO || lcnt_q == `APM_BAD_HI) begin
                            x_abort = 1'b1;
                        end else begin
                            x_feat[`F_APM] = 1'b1;
                            x_apm          = lcnt_q;
                        end
                    end
                    `SC_APM_OFF:    x_feat[`F_APM] = 1'b0;
                    `SC_STBY_ON:    x_feat[`F_STBY] = 1'b1;
                    `SC_STBY_OFF:   x_feat[`F_STBY] = 1'b0;
                    `SC_SPINUP:     x_spin = 1'b1;
                    `SC_LOOK_ON:    x_feat[`F_LOOK] = 1'b1;
                    `SC_LOOK_OFF:   x_feat[`F_LOOK] = 1'b0;
                    `SC_REVERT_ON:  x_feat[`F_REVERT] = 1'b1;
                    `SC_REVERT_OFF: x_feat[`F_REVERT] = 1'b0;
                    `SC_RELINT_ON:  x_feat[`F_RELINT] = 1'b1;
                    `SC_RELINT_OFF: x_feat[`F_RELINT] = 1'b0;
                    `SC_SVCINT_ON:  x_feat[`F_SVCINT] = 1'b1;
                    `SC_SVCINT_OFF: x_feat[`F_SVCINT] = 1'b0;
                    `SC_MEDIA_ON, `SC_MEDIA_OFF: begin
                        if (REMOVABLE == 0) begin
                            x_abort = 1'b1;
                        end else begin
                            x_feat[`F_MEDIA] = lsub_q[7];
                            x_media          = lsub_q[7];
                        end
                    end
                    `SC_CARDPWR_ON, `SC_CARDPWR_OFF: begin
                        if (CARD_CLASS == 0)
                            x_abort = 1'b1;
                        else
                            x_feat[`F_CARDPWR] = ~lsub_q[7];
                    end
                    `SC_DATA8_ON, `SC_DATA8_OFF: begin
                        if (CARD_CLASS == 0)
                            x_abort = 1'b1;
                        else
                            x_feat[`F_DATA8] = ~lsub_q[7];
                    end
                    default: x_abort = 1'b1;
                endcase
            end
            `CMD_SERVICE: x_abort = ~svc_pend_q;
            `CMD_SEEK:    x_abort = 1'b0;
            default:      x_abort = 1'b1;
        endcase
    end

    // ****************************************
    // Bus, registers and command sequencing
    // ****************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            state_q     <= S_IDLE;
            sel_q       <= `RST_BYTE;
            cnt_q       <= `RST_BYTE;
            num_q       <= `RST_BYTE;
            lo_q        <= `RST_BYTE;
            hi_q        <= `RST_BYTE;
            unit_q      <= `RST_BYTE;
            err_q       <= `RST_BYTE;
            stat_q      <= `RST_STATUS;
            lcmd_q      <= `RST_BYTE;
            lsub_q      <= `RST_BYTE;
            lcnt_q      <= `RST_BYTE;
            svc_pend_q  <= 1'b0;
            rstat_q     <= `RST_BYTE;
            rerr_q      <= `RST_BYTE;
            rcnt_q      <= `RST_BYTE;
            wr_q        <= 1'b0;
            waddr_q     <= `RST_BYTE;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            feature_en  <= FEAT_DEFAULT;
            pio_mode    <= PIO_DEFAULT;
            dma_mode    <= DMA_DEFAULT;
            apm_level   <= APM_DEFAULT;
            spinup      <= 1'b0;
            cache_flush <= 1'b0;
            data_out    <= `RST_DATA;
        end else begin
            // Zero wait states: read data is ready in the data phase
            wr_q    <= addr_ph & hwrite;
            waddr_q <= haddr;
            hrdata  <= 32'h00000000;
            spinup      <= 1'b0;
            cache_flush <= 1'b0;
            if (addr_ph & ~hwrite) begin
                case ({haddr[7:2], 2'b00})
                    `OFF_PARAMETER_COUNT:  hrdata[7:0] <= cnt_q;
                    `OFF_PARAMETER_NUMBER: hrdata[7:0] <= num_q;
                    `OFF_PARAMETER_LOW:    hrdata[7:0] <= lo_q;
                    `OFF_PARAMETER_HIGH:   hrdata[7:0] <= hi_q;
                    `OFF_UNIT_SELECT:      hrdata[7:0] <= unit_q;
                    `OFF_FAULT_DETAIL:     hrdata[7:0] <= err_q;
                    `OFF_UNIT_CONDITION:   hrdata[7:0] <= stat_rd;
                    `OFF_FEATURE_STATE:    hrdata[9:0] <= feature_en;
                    `OFF_TRANSFER_STATE:   hrdata      <= {8'h00, apm_level, dma_mode, pio_mode};
                    `OFF_DATA_PORT:        hrdata[15:0] <= data_out;
                    default:               hrdata <= 32'h00000000;
                endcase
            end
            if (wr_q) begin
                case ({waddr_q[7:2], 2'b00})
                    `OFF_SUBCOMMAND_SELECT: sel_q  <= hwdata[7:0];
                    `OFF_PARAMETER_COUNT:   cnt_q  <= hwdata[7:0];
                    `OFF_PARAMETER_NUMBER:  num_q  <= hwdata[7:0];
                    `OFF_PARAMETER_LOW:     lo_q   <= hwdata[7:0];
                    `OFF_PARAMETER_HIGH:    hi_q   <= hwdata[7:0];
                    `OFF_UNIT_SELECT:       unit_q <= hwdata[7:0];
                    `OFF_DATA_PORT: begin
                        if (feature_en[`F_DATA8])
                            data_out <= {8'h00, hwdata[7:0]};
                        else
                            data_out <= hwdata[15:0];
                    end
                    `OFF_COMMAND_CODE: begin
                        // A command written while busy is dropped
                        if (state_q == S_IDLE) begin
                            lcmd_q  <= hwdata[7:0];
                            lsub_q  <= sel_q;
                            lcnt_q  <= cnt_q;
                            err_q   <= `RST_BYTE;
                            stat_q  <= 8'h80 | (stat_q & 8'h40);
                            state_q <= S_EXEC;
                        end
                    end
                    default: ;
                endcase
            end
            // Set wins over the clear done by a service completion
            if (rel_valid) begin
                rstat_q <= rel_status;
                rerr_q  <= rel_error;
                rcnt_q  <= rel_count;
            end
            case (state_q)
                S_IDLE: begin
                    if (rel_valid)
                        svc_pend_q <= 1'b1;
                end
                S_EXEC: begin
                    state_q <= S_IDLE;
                    if (lcmd_q == `CMD_SERVICE && !x_abort) begin
                        err_q      <= rerr_q;
                        cnt_q      <= rcnt_q;
                        stat_q     <= {1'b0, rstat_q[6:1], |rerr_q};
                        svc_pend_q <= rel_valid;
                    end else begin
                        if (rel_valid)
                            svc_pend_q <= 1'b1;
                        err_q  <= {5'h00, x_abort, 2'b00};
                        stat_q <= {1'b0, 1'b1, device_fault, 1'b0, 1'b0, 2'b00, x_abort};
                        if (!x_abort) begin
                            feature_en  <= x_feat;
                            pio_mode    <= x_pio;
                            dma_mode    <= x_dma;
                            apm_level   <= x_apm;
                            spinup      <= x_spin;
                            cache_flush <= x_flush;
                            if (x_media) begin
                                lo_q <= 8'h00;
                                hi_q <= {5'h00, CAN_EJECT != 0, CAN_LOCK != 0,
                                         feature_en[`F_MEDIA]};
                            end
                            if (lcmd_q == `CMD_SEEK)
                                state_q <= S_SEEK;
                        end
                    end
                end
                S_SEEK: begin
                    // Seek done follows ready by one cycle
                    if (rel_valid)
                        svc_pend_q <= 1'b1;
                    stat_q[`ST_SEEKDONE] <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule // set_features_service_cmd
`default_nettype wire

// >>> dv/sfs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "set_features_service_cmd_defs.vh"
module sfs_assertions #(
    parameter CARD_CLASS = 0
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Back end
    input wire logic        rel_valid,
    input wire logic [7:0]  rel_status,
    input wire logic [7:0]  rel_error,
    input wire logic [7:0]  rel_count,
    input wire logic        device_fault,
    // Features
    input wire logic [9:0]  feature_en,
    input wire logic [7:0]  pio_mode,
    input wire logic [7:0]  dma_mode,
    input wire logic [7:0]  apm_level,
    input wire logic        spinup,
    input wire logic        cache_flush,
    input wire logic [15:0] data_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic       rd_q;
    logic [7:0] ra_q;
    wire        cmd_take = hsel && hready && htrans[1] && hwrite && haddr == `OFF_COMMAND_CODE;
    always @(posedge sys_clk) begin
        if (rst) begin
            rd_q <= 1'b0;
            ra_q <= 8'h00;
        end else begin
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            ra_q <= haddr;
        end
    end
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_rdata_idle;
        !rd_q |-> hrdata == 32'h0;
    endproperty
    property p_status_done;
        rd_q && ra_q == `OFF_UNIT_CONDITION && !hrdata[`ST_BUSY]
            |-> hrdata[`ST_READY] && !hrdata[`ST_XFERREQ] && hrdata[31:8] == 24'h0;
    endproperty
    property p_spin_pulse;
        spinup |=> !spinup;
    endproperty
    property p_flush_off;
        cache_flush |-> !feature_en[`F_WCACHE] ##1 !cache_flush;
    endproperty
    property p_no_narrow;
        CARD_CLASS == 0 |-> !feature_en[`F_DATA8] && !feature_en[`F_CARDPWR];
    endproperty
    property p_dma_one;
        !(dma_mode[6] && dma_mode[5]);
    endproperty
    property p_apm_legal;
        apm_level != `APM_BAD_LO && apm_level != `APM_BAD_HI;
    endproperty
    // Feature and mode outputs move only three edges after a command address phase
    property p_cmd_cause;
        $changed({feature_en, pio_mode, dma_mode, apm_level}) |-> $past(cmd_take, 3);
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready okay");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside phase");
    a_status_done: assert property (p_status_done) else $error("idle status bad");
    a_spin_pulse: assert property (p_spin_pulse) else $error("spinup too long");
    a_flush_off: assert property (p_flush_off) else $error("flush with cache on");
    a_no_narrow: assert property (p_no_narrow) else $error("card mode enabled");
    a_dma_one: assert property (p_dma_one) else $error("two dma kinds");
    a_apm_legal: assert property (p_apm_legal) else $error("reserved apm level");
    a_cmd_cause: assert property (p_cmd_cause) else $error("output change w/o cmd");
    c_spin: cover property (spinup);
    c_flush: cover property (cache_flush);
    c_udma: cover property (dma_mode[6]);
endmodule // sfs_assertions
`default_nettype wire

// >>> dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic        sys_clk,
    // Bus
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [7:0]  haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hwdata <= ~hwdata; // Stale data never looks valid
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // host_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "set_features_service_cmd_defs.vh"
module tb;
    localparam int       N = 38;
    localparam [9:0]     FEAT_DEF = 10'h000;
    localparam [7:0]     APM_DEF = 8'hFE;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        rel_valid = 1'b0;
    logic [7:0]  rel_status = 8'h00;
    logic [7:0]  rel_error = 8'h00;
    logic [7:0]  rel_count = 8'h00;
    logic        device_fault = 1'b0;
    wire         hsel, hwrite, hreadyout, hresp, spinup, cache_flush;
    wire [7:0]   haddr, pio_mode, dma_mode, apm_level;
    wire [1:0]   htrans;
    wire [2:0]   hsize;
    wire [31:0]  hwdata, hrdata;
    wire [9:0]   feature_en;
    wire [15:0]  data_out;
    int          bad_count = 0;
    int          n_compared = 0;
    logic [31:0] q;
    logic [9:0]  ef;
    logic [7:0]  ep, ed, ea, s, n;
    logic [3:0]  ab, bt, vl;
    logic        pena;
    int          n_spin = 0;
    int          n_flush = 0;
    // One-cycle pulses are too short for bus reads, so count them here
    always @(posedge sys_clk) begin
        if (spinup === 1'b1) n_spin <= n_spin + 1;
        if (cache_flush === 1'b1) n_flush <= n_flush + 1;
    end
    // Subcommand, count, abort, feature bit (F none), new value
    logic [27:0] t [N] = '{
        28'h02_00_001, 28'h82_00_000, 28'h05_80_011, 28'h05_00_1F0, 28'h05_FF_1F0,
        28'h85_00_010, 28'h06_00_021, 28'h86_00_020, 28'hAA_00_031, 28'h55_00_030,
        28'hCC_00_041, 28'h66_00_040, 28'h5D_00_051, 28'hDD_00_050, 28'h5E_00_061,
        28'hDE_00_060, 28'h95_00_071, 28'h95_00_071, 28'h31_00_070, 28'h07_00_0F0,
        28'h01_00_1F0, 28'h81_00_1F0, 28'h0A_00_1F0, 28'h8A_00_1F0, 28'hF0_00_1F0,
        28'hFF_00_1F0, 28'h04_00_1F0, 28'h00_00_1F0, 28'h03_0C_0F0, 28'h03_0D_1F0,
        28'h03_22_0F0, 28'h03_45_0F0, 28'h03_23_1F0, 28'h03_46_1F0, 28'h03_80_1F0,
        28'h03_10_1F0, 28'h03_01_0F0, 28'h03_00_0F0};
    always #2.5 sys_clk = ~sys_clk;
    host_model host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    set_features_service_cmd #(.FEAT_DEFAULT(FEAT_DEF), .APM_DEFAULT(APM_DEF), .CARD_CLASS(0),
        .CAN_LOCK(1), .CAN_EJECT(1)) uut (
        .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rel_valid(rel_valid),
        .rel_status(rel_status), .rel_error(rel_error), .rel_count(rel_count),
        .device_fault(device_fault), .feature_en(feature_en), .pio_mode(pio_mode),
        .dma_mode(dma_mode), .apm_level(apm_level), .spinup(spinup),
        .cache_flush(cache_flush), .data_out(data_out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic idle;
        for (int i = 0; i < 50; i++) begin
            rd(`OFF_UNIT_CONDITION);
            if (q[`ST_BUSY] === 1'b0 && q[`ST_READY] === 1'b1) break;
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] sc, input logic [7:0] cn);
        idle();
        wr(`OFF_SUBCOMMAND_SELECT, {24'h0, sc});
        wr(`OFF_PARAMETER_COUNT, {24'h0, cn});
        wr(`OFF_COMMAND_CODE, {24'h0, c});
        idle();
    endtask
    task automatic done(input logic [7:0] st, input logic [7:0] er);
        rd(`OFF_UNIT_CONDITION);
        chk(q, {24'h0, st});
        rd(`OFF_FAULT_DETAIL);
        chk(q, {24'h0, er});
    endtask
    task automatic svc(input logic [7:0] st, er, ct, xs);
        rel_valid <= 1'b1;
        rel_status <= st;
        rel_error <= er;
        rel_count <= ct;
        @(posedge sys_clk);
        rel_valid <= 1'b0;
        idle();
        chk({31'h0, q[`ST_SERVICE]}, 32'h1);
        cmd(`CMD_SERVICE, 8'h00, 8'h99);
        done(xs, er);
        rd(`OFF_PARAMETER_COUNT);
        chk(q, {24'h0, ct});
    endtask
    task automatic report_and_stop;
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        $display("wrong value at %0t: run hung", $time);
        report_and_stop();
    end
    initial begin
        ef = FEAT_DEF;
        ea = APM_DEF;
        ep = 8'h00;
        ed = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        done(8'h40, 8'h00);
        rd(8'h3C);
        chk(q, 32'h0);
        chk({22'h0, feature_en}, {22'h0, ef});
        chk({8'h0, apm_level, dma_mode, pio_mode}, {8'h0, ea, 16'h0});
        $display("test reset done");
        for (int i = 0; i < N; i++) begin
            {s, n, ab, bt, vl} = t[i];
            pena = ef[`F_MEDIA];
            cmd(`CMD_SETFEAT, s, n);
            if (ab[0]) done(8'h41, 8'h04);
            else done(8'h40, 8'h00);
            if (!ab[0] && bt != 4'hF) ef[bt] = vl[0];
            if (!ab[0] && s == `SC_APM_ON) ea = n;
            if (!ab[0] && s == `SC_XFER_MODE && n[7:4] == 4'h0) ep = n;
            else if (!ab[0] && s == `SC_XFER_MODE) ed = n;
            chk({22'h0, feature_en}, {22'h0, ef});
            chk({8'h0, apm_level, dma_mode, pio_mode}, {8'h0, ea, ed, ep});
            if (s == `SC_MEDIA_ON) begin
                rd(`OFF_PARAMETER_HIGH);
                chk(q, {29'h0, 1'b1, 1'b1, pena});
            end
        end
        $display("test subcommands done");
        device_fault <= 1'b1;
        cmd(`CMD_SETFEAT, `SC_WCACHE_ON, 8'h00);
        done(8'h60, 8'h00);
        device_fault <= 1'b0;
        cmd(8'h20, 8'h00, 8'h00);
        done(8'h41, 8'h04);
        cmd(`CMD_SERVICE, 8'h00, 8'h00);
        done(8'h41, 8'h04);
        // Resumed status without a data request, as the idle status check expects
        svc(8'h50, 8'h00, 8'h11, 8'h50);
        svc(8'hD0, 8'h10, 8'h22, 8'h51);
        $display("test service done");
        cmd(`CMD_SEEK, 8'h00, 8'h00);
        done(8'h50, 8'h00);
        wr(`OFF_DATA_PORT, 32'h0000ABCD);
        @(posedge sys_clk);
        chk({16'h0, data_out}, 32'h0000ABCD);
        chk(n_spin, 32'h1);
        chk(n_flush, 32'h1);
        $display("test seek and data done");
        report_and_stop();
    end
endmodule // tb
bind set_features_service_cmd sfs_assertions #(.CARD_CLASS(CARD_CLASS)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rel_valid(rel_valid), .rel_status(rel_status),
    .rel_error(rel_error), .rel_count(rel_count), .device_fault(device_fault),
    .feature_en(feature_en), .pio_mode(pio_mode), .dma_mode(dma_mode),
    .apm_level(apm_level), .spinup(spinup), .cache_flush(cache_flush), .data_out(data_out));
`default_nettype wire
